/* File: hw/fsp_consts.svh */
// constants of the flash self-program controller: offsets, field positions, reset values, timing
// assumes a 125 MHz system clock and a calibrated rc oscillator level arriving on a pin
`ifndef FSP_CONSTS_SVH
`define FSP_CONSTS_SVH

// ----------------------------------------
// control byte fields
// ----------------------------------------
`define FSP_BIT_STORE_EN 0
`define FSP_BIT_ERASE 1
`define FSP_BIT_WRITE 2
`define FSP_BIT_LOCK 3
`define FSP_BIT_REEN 4
`define FSP_BIT_BUSY 6
`define FSP_BIT_RIE 7
`define FSP_CTRL_RESET 8'h00
`define FSP_OP_LOAD 5'h01
`define FSP_OP_ERASE 5'h03
`define FSP_OP_WRITE 5'h05
`define FSP_OP_LOCK 5'h09
`define FSP_OP_REEN 5'h11

// ----------------------------------------
// address map, in program words
// ----------------------------------------
`define FSP_BOOT_START_11 14'h3f00
`define FSP_BOOT_START_10 14'h3e00
`define FSP_BOOT_START_01 14'h3c00
`define FSP_BOOT_START_00 14'h3800
`define FSP_HALT_BASE 14'h3800
`define FSP_PTR_PAGE_HI 14
`define FSP_PTR_PAGE_LO 7
`define FSP_PTR_WORD_HI 6
`define FSP_PTR_WORD_LO 1
`define FSP_PAGE_LSB 6

// ----------------------------------------
// timing
// ----------------------------------------
`define FSP_WINDOW_CLKS 3'h4
`define FSP_CLK_PERIOD_NS 8
`define FSP_T_MIN_NS 3700000
`define FSP_T_MAX_NS 4500000
`define FSP_MIN_CYC ((`FSP_T_MIN_NS + `FSP_CLK_PERIOD_NS - 1) / `FSP_CLK_PERIOD_NS)
`define FSP_MAX_CYC (`FSP_T_MAX_NS / `FSP_CLK_PERIOD_NS)
`define FSP_RC_HZ 1000000
`define FSP_T_TARGET_US 4100
`define FSP_RC_TICKS (`FSP_T_TARGET_US * (`FSP_RC_HZ / 1000000))

`endif

/* File: hw/fsp_pkg.sv */
// types of the flash self-program controller
// assumes fsp_consts.svh for every figure
package fsp_pkg;

    typedef enum logic [1:0] {FSP_IDLE, FSP_WINDOW, FSP_BUSY} fsp_phase_e;

    typedef enum logic [2:0] {FSP_CMD_NONE, FSP_CMD_LOAD, FSP_CMD_ERASE, FSP_CMD_WRITE,
                              FSP_CMD_LOCK, FSP_CMD_REEN} fsp_cmd_e;

    typedef struct packed {
        logic [15:0] ptr;
        logic [15:0] data;
    } fsp_store_s;

    typedef struct packed {
        fsp_phase_e phase;
        fsp_cmd_e cmd;
        logic [2:0] win;
        logic [4:0] ctrl;
        logic rie;
        logic region_busy;
        logic [7:0] page;
        logic [15:0] ticks;
        logic [19:0] cyc;
        logic [2:0] rc_sync;
        logic rc_lvl;
        logic [5:0] fuse_sync;
        logic [1:0] fuse_lvl;
        logic [13:0] boot_start;
        logic halt;
        logic busy;
        logic fetch_ok;
        logic buf_load;
        logic buf_clear;
        logic [5:0] word;
        logic [15:0] wdata;
        logic lock_done;
        logic byte_sel;
        logic [7:0] rdata;
    } fsp_state_s;

endpackage

/* File: hw/fsp_ctrl.sv */
// flash self-program controller: command window, operation timer, region tracking, fetch gating
// assumes the core issues store/load strobes one cycle wide and reads the status byte each cycle
`timescale 1ns/100ps
`default_nettype none
`include "fsp_consts.svh"

// Overview of operation
// - boot-size fuse picks boot start 0x3F00, 0x3E00, 0x3C00 or 0x3800; ends 0x3FFF.
// - words below 0x3800 form the concurrent region; 0x3800 up is the halting region.
// - during erase or page write only halting-region fetches are allowed.
// - program word address is 14 bits; bits 5:0 word, bits 13:6 page.
// - erase and page write take the page from pointer bits 14:7.
// - buffer fill takes word from pointer bits 6:1; software zeroes them on write.
// - pointer bit 15 ignored; bit 0 zero for stores, byte select for loads.
// - each erase, write or lock operation lasts 3.7 ms to 4.5 ms.
// - operation time comes from the calibrated rc oscillator.
// - reset during a flash operation lets that operation finish.
// - control bits: store-en 0, erase 1, write 2, lock 3, reenable 4, busy 6, irq-en 7.
// - store-enable opens four clocks; clears unused; held during erase or write.
// - region-busy set by concurrent-region erase/write; cleared by reenable or page load.
// - halt the core through erase or write of a halting-region page.
module fsp_ctrl #(
    parameter int MIN_CYC = `FSP_MIN_CYC,
    parameter int MAX_CYC = `FSP_MAX_CYC,
    parameter int OP_RC_TICKS = `FSP_RC_TICKS
) (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CTRL_WE,
    input wire logic [7:0] CTRL_WDATA,
    input wire logic EEPROM_WRITE_PENDING,
    input wire logic STORE_EXEC,
    input wire logic LOAD_EXEC,
    input wire fsp_pkg::fsp_store_s STORE_IN,
    input wire logic RC_OSC,
    input wire logic [1:0] BOOT_SIZE_SEL,
    input wire logic [13:0] FETCH_ADDR,
    output logic [7:0] CTRL_RDATA,
    output logic FLASH_BUSY,
    output logic CPU_HALT,
    output logic FETCH_ALLOWED,
    output logic [7:0] PAGE_INDEX,
    output logic [5:0] WORD_IN_PAGE_INDEX,
    output logic [15:0] BUF_WDATA,
    output logic BUF_LOAD,
    output logic BUF_CLEAR,
    output logic LOCK_DONE,
    output logic LOAD_BYTE_SEL,
    output logic [13:0] BOOT_START
);

    fsp_pkg::fsp_state_s s_q;
    fsp_pkg::fsp_state_s s_d;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic in_halting(input logic [13:0] addr);
        in_halting = (addr >= `FSP_HALT_BASE);
    endfunction

    function automatic logic [13:0] boot_base(input logic [1:0] sel);
        logic [13:0] b;
        b = `FSP_BOOT_START_00;
        unique case (sel)
            2'h3: b = `FSP_BOOT_START_11;
            2'h2: b = `FSP_BOOT_START_10;
            2'h1: b = `FSP_BOOT_START_01;
            2'h0: b = `FSP_BOOT_START_00;
        endcase
        boot_base = b;
    endfunction

    logic [7:0] ptr_page;
    logic [5:0] ptr_word;
    logic erase_or_write;
    logic rc_tick;
    logic op_over;
    assign ptr_page = STORE_IN.ptr[`FSP_PTR_PAGE_HI:`FSP_PTR_PAGE_LO];
    assign ptr_word = STORE_IN.ptr[`FSP_PTR_WORD_HI:`FSP_PTR_WORD_LO];
    assign erase_or_write = (s_q.cmd == fsp_pkg::FSP_CMD_ERASE) || (s_q.cmd == fsp_pkg::FSP_CMD_WRITE);
    // a tick is a rising edge of the rc level once the second and third stages agree
    assign rc_tick = s_q.rc_sync[1] & s_q.rc_sync[2] & ~s_q.rc_lvl;
    // rc ticks set the length; the system-clock bounds only guard a drifting or stopped oscillator
    assign op_over = ((s_q.ticks >= 16'(OP_RC_TICKS)) && (s_q.cyc >= 20'(MIN_CYC)))
                     || (s_q.cyc >= 20'(MAX_CYC));

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.buf_load = 1'b0;
        s_d.buf_clear = 1'b0;
        s_d.lock_done = 1'b0;
        s_d.rc_sync = {s_q.rc_sync[1:0], RC_OSC};
        if (s_q.rc_sync[1] == s_q.rc_sync[2]) begin
            s_d.rc_lvl = s_q.rc_sync[2];
        end
        s_d.fuse_sync = {s_q.fuse_sync[3:0], BOOT_SIZE_SEL};
        if (s_q.fuse_sync[3:2] == s_q.fuse_sync[5:4]) begin
            s_d.fuse_lvl = s_q.fuse_sync[5:4];
        end
        s_d.boot_start = boot_base(s_q.fuse_lvl);
        if (LOAD_EXEC) begin
            s_d.byte_sel = STORE_IN.ptr[0];
        end
        unique case (s_q.phase)
            fsp_pkg::FSP_IDLE: begin
                // a write while eeprom is busy or with an unlisted pattern changes nothing but the irq enable
                if (CTRL_WE) begin
                    s_d.rie = CTRL_WDATA[`FSP_BIT_RIE];
                    if (!EEPROM_WRITE_PENDING) begin
                        s_d.phase = fsp_pkg::FSP_WINDOW;
                        s_d.win = `FSP_WINDOW_CLKS;
                        s_d.ctrl = CTRL_WDATA[4:0];
                        unique case (CTRL_WDATA[4:0])
                            `FSP_OP_LOAD: s_d.cmd = fsp_pkg::FSP_CMD_LOAD;
                            `FSP_OP_ERASE: s_d.cmd = fsp_pkg::FSP_CMD_ERASE;
                            `FSP_OP_WRITE: s_d.cmd = fsp_pkg::FSP_CMD_WRITE;
                            `FSP_OP_LOCK: s_d.cmd = fsp_pkg::FSP_CMD_LOCK;
                            `FSP_OP_REEN: s_d.cmd = fsp_pkg::FSP_CMD_REEN;
                            default: begin
                                s_d.phase = fsp_pkg::FSP_IDLE;
                                s_d.ctrl = s_q.ctrl;
                            end
                        endcase
                    end
                end
            end
            fsp_pkg::FSP_WINDOW: begin
                if (STORE_EXEC) begin
                    s_d.page = ptr_page;
                    s_d.ticks = 16'h0000;
                    s_d.cyc = 20'h00000;
                    s_d.phase = fsp_pkg::FSP_IDLE;
                    s_d.ctrl = 5'h00;
                    unique case (s_q.cmd)
                        fsp_pkg::FSP_CMD_LOAD: begin
                            s_d.buf_load = 1'b1;
                            s_d.word = ptr_word;
                            s_d.wdata = STORE_IN.data;
                            s_d.region_busy = 1'b0;
                        end
                        fsp_pkg::FSP_CMD_REEN: begin
                            s_d.buf_clear = 1'b1;
                            s_d.region_busy = 1'b0;
                        end
                        fsp_pkg::FSP_CMD_ERASE, fsp_pkg::FSP_CMD_WRITE: begin
                            s_d.phase = fsp_pkg::FSP_BUSY;
                            s_d.ctrl = s_q.ctrl;
                            if (!in_halting({ptr_page, 6'h00})) begin
                                s_d.region_busy = 1'b1;
                            end
                        end
                        fsp_pkg::FSP_CMD_LOCK: begin
                            s_d.phase = fsp_pkg::FSP_BUSY;
                            s_d.ctrl = s_q.ctrl;
                        end
                        default: begin
                            s_d.phase = fsp_pkg::FSP_IDLE;
                        end
                    endcase
                end else if (s_q.win == 3'h1) begin
                    s_d.phase = fsp_pkg::FSP_IDLE;
                    s_d.ctrl = 5'h00;
                    s_d.cmd = fsp_pkg::FSP_CMD_NONE;
                end else begin
                    s_d.win = s_q.win - 3'h1;
                end
            end
            fsp_pkg::FSP_BUSY: begin
                // control writes are dropped here; the core must poll store-enable first
                if (rc_tick) begin
                    s_d.ticks = s_q.ticks + 16'h0001;
                end
                if (op_over) begin
                    s_d.phase = fsp_pkg::FSP_IDLE;
                    s_d.ctrl = 5'h00;
                    s_d.buf_clear = (s_q.cmd == fsp_pkg::FSP_CMD_WRITE);
                    s_d.lock_done = (s_q.cmd == fsp_pkg::FSP_CMD_LOCK);
                    s_d.cmd = fsp_pkg::FSP_CMD_NONE;
                end else begin
                    // the count freezes at the end so it never passes the cycle limit
                    s_d.cyc = s_q.cyc + 20'h00001;
                end
            end
            default: begin
                s_d.phase = fsp_pkg::FSP_IDLE;
            end
        endcase
        s_d.halt = (s_d.phase == fsp_pkg::FSP_BUSY) && in_halting({s_d.page, 6'h00})
                   && ((s_d.cmd == fsp_pkg::FSP_CMD_ERASE) || (s_d.cmd == fsp_pkg::FSP_CMD_WRITE));
        s_d.fetch_ok = in_halting(FETCH_ADDR) || !(s_d.region_busy
                       || ((s_d.phase == fsp_pkg::FSP_BUSY) && (s_d.cmd != fsp_pkg::FSP_CMD_LOCK)));
        if (!RST_N) begin
            // a running flash operation survives reset with only the irq enable cleared; outside an operation everything restarts
            if (s_q.phase == fsp_pkg::FSP_BUSY) begin
                s_d.rie = 1'b0;
            end else begin
                s_d = '0;
                s_d.phase = fsp_pkg::FSP_IDLE;
                s_d.cmd = fsp_pkg::FSP_CMD_NONE;
                s_d.fetch_ok = 1'b1;
                s_d.buf_clear = 1'b1;
                s_d.boot_start = `FSP_BOOT_START_00;
            end
        end
        s_d.rdata = `FSP_CTRL_RESET;
        s_d.rdata[4:0] = s_d.ctrl;
        s_d.rdata[`FSP_BIT_BUSY] = s_d.region_busy;
        s_d.rdata[`FSP_BIT_RIE] = s_d.rie;
        s_d.busy = (s_d.phase == fsp_pkg::FSP_BUSY);
    end

    always_ff @(posedge CLK_SYS) begin
        s_q <= s_d;
    end

    assign CTRL_RDATA = s_q.rdata;
    assign FLASH_BUSY = s_q.busy;
    assign CPU_HALT = s_q.halt;
    assign FETCH_ALLOWED = s_q.fetch_ok;
    assign PAGE_INDEX = s_q.page;
    assign WORD_IN_PAGE_INDEX = s_q.word;
    assign BUF_WDATA = s_q.wdata;
    assign BUF_LOAD = s_q.buf_load;
    assign BUF_CLEAR = s_q.buf_clear;
    assign LOCK_DONE = s_q.lock_done;
    assign LOAD_BYTE_SEL = s_q.byte_sel;
    assign BOOT_START = s_q.boot_start;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    chk_window_expiry: assert property ((s_q.phase == fsp_pkg::FSP_WINDOW && s_q.win == 3'h1 && !STORE_EXEC)
        |=> s_q.phase == fsp_pkg::FSP_IDLE && CTRL_RDATA[`FSP_BIT_STORE_EN] == 1'b0)
        else $error("store window did not close after four clocks");
    chk_store_held: assert property (FLASH_BUSY |-> CTRL_RDATA[`FSP_BIT_STORE_EN])
        else $error("store-enable low during operation");
    chk_min_time: assert property ($rose(FLASH_BUSY) |-> FLASH_BUSY [*8])
        else $error("operation ended too soon");
    chk_max_time: assert property (s_q.cyc <= 20'(MAX_CYC))
        else $error("operation exceeded maximum time");
    chk_fetch_block: assert property ((FLASH_BUSY && erase_or_write && !op_over && !in_halting(FETCH_ADDR))
        |=> !FETCH_ALLOWED)
        else $error("concurrent region fetched during operation");
    chk_halt_region: assert property (CPU_HALT |-> FLASH_BUSY && in_halting({PAGE_INDEX, 6'h00}))
        else $error("halt outside halting-region operation");
    chk_busy_set: assert property ((s_q.phase == fsp_pkg::FSP_WINDOW && STORE_EXEC && erase_or_write
        && !in_halting({ptr_page, 6'h00})) |=> CTRL_RDATA[`FSP_BIT_BUSY])
        else $error("region-busy not set");
    chk_load_clear: assert property ((s_q.phase == fsp_pkg::FSP_WINDOW && STORE_EXEC
        && s_q.cmd == fsp_pkg::FSP_CMD_LOAD) |=> BUF_LOAD && !CTRL_RDATA[`FSP_BIT_BUSY]
        && WORD_IN_PAGE_INDEX == $past(ptr_word))
        else $error("page load wrong");
    chk_busy_ignore: assert property ((FLASH_BUSY && CTRL_WE && !op_over) |=> FLASH_BUSY
        && $stable(CTRL_RDATA[4:0]))
        else $error("command taken while busy");
    chk_boot_map: assert property ((s_q.fuse_lvl == 2'h3) |=> BOOT_START == `FSP_BOOT_START_11)
        else $error("boot start wrong");

    cov_erase: cover property ($rose(FLASH_BUSY) && s_q.cmd == fsp_pkg::FSP_CMD_ERASE);
    cov_halt: cover property ($rose(CPU_HALT));
    cov_expire: cover property (s_q.phase == fsp_pkg::FSP_WINDOW && s_q.win == 3'h1 && !STORE_EXEC);
    cov_reen: cover property ($fell(CTRL_RDATA[`FSP_BIT_BUSY]));

endmodule
`default_nettype wire

/* File: tb/fsp_core_model.sv */
// core partner model: control writes and store strobes toward the controller
// assumes the controller samples on the rising clock edge; this model drives on the falling one
`timescale 1ns/100ps
`default_nettype none
module fsp_core_model (
    input wire logic CLK_SYS,
    input wire logic [7:0] CTRL_RDATA,
    input wire logic EEPROM_WRITE_PENDING,
    output var logic CTRL_WE,
    output var logic [7:0] CTRL_WDATA,
    output var logic STORE_EXEC,
    output var logic LOAD_EXEC,
    output var fsp_pkg::fsp_store_s STORE_IN
);
    bit stuck;
    initial begin
        CTRL_WE = 1'b0;
        CTRL_WDATA = 8'h00;
        STORE_EXEC = 1'b0;
        LOAD_EXEC = 1'b0;
        STORE_IN = '0;
    end
    // go=0 writes the control byte alone, without polling, to provoke refusals
    task automatic spm(input logic [7:0] c, input logic [31:0] s, input bit go);
        int n;
        n = 0;
        @(negedge CLK_SYS);
        while (go && n < 900 && (CTRL_RDATA[0] !== 1'b0 || EEPROM_WRITE_PENDING !== 1'b0)) begin
            @(negedge CLK_SYS);
            n++;
        end
        if (n >= 900) begin
            stuck = 1'b1;
        end
        CTRL_WE = 1'b1;
        CTRL_WDATA = c;
        @(negedge CLK_SYS);
        CTRL_WE = 1'b0;
        CTRL_WDATA = ~c;
        // store right behind the write so that nothing can slip in and close the window
        STORE_EXEC = go;
        STORE_IN = s;
        @(negedge CLK_SYS);
        STORE_EXEC = 1'b0;
        STORE_IN = ~s;
    endtask
    // load-program strobe: only pointer bit 0 matters to the controller
    task automatic lpm(input logic [15:0] z);
        @(negedge CLK_SYS);
        LOAD_EXEC = 1'b1;
        STORE_IN = {z, 16'h0000};
        @(negedge CLK_SYS);
        LOAD_EXEC = 1'b0;
        STORE_IN = ~{z, 16'h0000};
    endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench of the flash self-program controller driven through a core model
// assumes the package, the controller and the core model are compiled before this file
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam int min_c = 20;
    localparam int max_c = 200;
    localparam logic [13:0] boot_tab [4] = '{14'h3800, 14'h3c00, 14'h3e00, 14'h3f00};
    logic clk, rst_n, eep, rc, rc_run, f_ok, busy, halt, bload, we, st, ld, bclr, ldone, bsel;
    logic [1:0] fuse;
    logic [13:0] faddr, bstart;
    logic [7:0] rdata, wdata, page;
    logic [5:0] word;
    logic [15:0] bwd, rnd, p;
    fsp_pkg::fsp_store_s sin;
    int bad_count, n_tests, m_op, m_reg, cyc, t0, d;

    fsp_ctrl #(.MIN_CYC(min_c), .MAX_CYC(max_c), .OP_RC_TICKS(5)) dut (.CLK_SYS(clk), .RST_N(rst_n),
        .CTRL_WE(we), .CTRL_WDATA(wdata), .EEPROM_WRITE_PENDING(eep), .STORE_EXEC(st), .LOAD_EXEC(ld),
        .STORE_IN(sin), .RC_OSC(rc), .BOOT_SIZE_SEL(fuse), .FETCH_ADDR(faddr), .CTRL_RDATA(rdata),
        .FLASH_BUSY(busy), .CPU_HALT(halt), .FETCH_ALLOWED(f_ok), .PAGE_INDEX(page), .WORD_IN_PAGE_INDEX(word),
        .BUF_WDATA(bwd), .BUF_LOAD(bload), .BUF_CLEAR(bclr), .LOCK_DONE(ldone), .LOAD_BYTE_SEL(bsel),
        .BOOT_START(bstart));
    fsp_core_model core (.CLK_SYS(clk), .CTRL_RDATA(rdata), .EEPROM_WRITE_PENDING(eep), .CTRL_WE(we),
        .CTRL_WDATA(wdata), .STORE_EXEC(st), .LOAD_EXEC(ld), .STORE_IN(sin));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        rc = 1'b0;
        forever #37 rc = rc_run ? ~rc : rc;
    end
    always @(posedge clk) cyc <= cyc + 1;

    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic fetch(input logic [13:0] a);
        faddr = a;
        @(negedge clk);
        check("fetch", 16'(f_ok), 16'(a >= 14'h3800 || (m_reg == 0 && m_op == 0)));
    endtask
    task automatic run_op();
        int n;
        for (n = 0; n < 900 && busy !== 1'b0; n++) begin
            @(negedge clk);
        end
        if (n >= 900) begin
            bad_count++;
            finish_test();
        end
        d = cyc - t0;
    endtask

    initial begin
        rst_n = 1'b0;
        eep = 1'b0;
        rc_run = 1'b1;
        fuse = 2'h3;
        faddr = 14'h0000;
        rnd = 16'h0028;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        check("status", 16'(rdata), 16'h0000);
        for (int i = 0; i < 4; i++) begin
            fuse = i[1:0];
            repeat (6) @(negedge clk);
            check("boot start", 16'(bstart), 16'(boot_tab[i]));
        end
        $display("test boot size done");
        rnd = lfsr(rnd);
        p = {rnd[15:1], 1'b0};
        core.spm(8'h01, {p, ~rnd}, 1'b1);
        check("buf load", 16'(bload), 16'h0001);
        check("word", 16'(word), 16'(p[6:1]));
        check("buf data", bwd, ~rnd);
        check("status", 16'(rdata), 16'h0000);
        core.spm(8'h01, 32'h0000_0000, 1'b0);
        repeat (2) @(negedge clk);
        check("window", 16'(rdata), 16'h0001);
        @(negedge clk);
        check("window end", 16'(rdata), 16'h0000);
        $display("test load and window done");
        rnd = lfsr(rnd);
        core.lpm(rnd);
        check("byte select", 16'(bsel), 16'(rnd[0]));
        core.lpm(~rnd);
        check("byte select", 16'(bsel), 16'(!rnd[0]));
        $display("test byte select done");
        rnd = lfsr(rnd);
        core.spm(8'h03, {2'h2, rnd[6:0], 7'h00, rnd}, 1'b1);
        t0 = cyc;
        m_op = 1;
        m_reg = 1;
        check("page", 16'(page), 16'({1'b0, rnd[6:0]}));
        check("status", 16'(rdata), 16'h0043);
        check("halt", 16'(halt), 16'h0000);
        fetch(14'h1234);
        fetch(14'h3900);
        core.spm(8'h05, 32'h0000_0000, 1'b0);
        check("refused", 16'(rdata), 16'h0043);
        run_op();
        m_op = 0;
        check("op time", 16'(d >= min_c - 1 && d < max_c - 50), 16'h0001);
        check("status", 16'(rdata), 16'h0040);
        fetch(14'h0100);
        core.spm(8'h11, 32'h0000_0000, 1'b1);
        m_reg = 0;
        check("reenable", 16'(rdata), 16'h0000);
        check("reenable clear", 16'(bclr), 16'h0001);
        fetch(14'h0100);
        $display("test erase done");
        // with the oscillator stopped only the cycle limit can end the operation
        rc_run = 1'b0;
        core.spm(8'h05, {4'h7, rnd[4:0], 7'h00, rnd}, 1'b1);
        t0 = cyc;
        m_op = 1;
        check("halt", 16'(halt), 16'h0001);
        fetch(14'h0100);
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        check("busy kept", 16'(busy), 16'h0001);
        run_op();
        check("max time", 16'(d >= max_c - 2 && d <= max_c + 2), 16'h0001);
        check("halt off", 16'(halt), 16'h0000);
        check("write clear", 16'(bclr), 16'h0001);
        $display("test page write done");
        core.spm(8'h09, 32'h0001_00ff, 1'b1);
        check("lock busy", 16'(busy), 16'h0001);
        check("lock halt", 16'(halt), 16'h0000);
        run_op();
        check("lock done", 16'(ldone), 16'h0001);
        $display("test lock done");
        // a pending eeprom write lets only the irq enable through
        eep = 1'b1;
        core.spm(8'h81, 32'h0000_0000, 1'b0);
        check("eeprom block", 16'(rdata), 16'h0080);
        eep = 1'b0;
        $display("test eeprom block done");
        check("poll bound", 16'(core.stuck), 16'h0000);
        finish_test();
    end
endmodule
`default_nettype wire
